// ===== core/spgc_top.v
// Behaviour
// - write one to bit 1 resets buffer/transfer
// - bit 1 reads one until that reset ends
// - bit 0 resets serial unit, reads busy
// - writing zero to reset bits does nothing
// - redundancy zero: common transmit-chosen clock, sync
// - shared mode ignores receive clock settings
// - redundancy one: receive, transmit clocking independent
// - receive enable runs or stops receive side
// - transmit enable runs or stops transmit side
// - source select picks side a or b
// - transmit config writes ignored while transmit enabled
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "spgc_map.vh"
`default_nettype none
module spgc_top #(
    parameter RESET_CYCLES = `SPGC_RESET_CYCLES,
    parameter CNT_W = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire timing_clock_side_a,
    input wire frame_sync_side_a,
    input wire timing_clock_side_b,
    input wire frame_sync_side_b,
    output reg serial_unit_reset_q,
    output reg buffer_unit_reset_q,
    output reg transfer_unit_reset_q,
    output reg tx_run_q,
    output reg rx_run_q,
    output reg dual_clock_mode_q,
    output reg tx_clk_q,
    output reg tx_fs_q,
    output reg rx_clk_q,
    output reg rx_fs_q,
    output reg tx_clk_rise_q,
    output reg rx_clk_rise_q
);

    localparam [31:0] RST_LOAD_W = RESET_CYCLES;
    localparam [CNT_W-1:0] RST_LOAD = RST_LOAD_W[CNT_W-1:0];

    // exact full-address decode; shared by read and write paths
    function is_reg;
        input [31:0] addr;
        input [7:0] off;
        begin
            is_reg = (addr[31:8] == 24'h000000) && (addr[7:0] == off);
        end
    endfunction

    function is_mapped;
        input [31:0] addr;
        begin
            is_mapped = is_reg(addr, `SPGC_OFF_RESET) || is_reg(addr, `SPGC_OFF_GLOBAL) ||
                        is_reg(addr, `SPGC_OFF_TX_SRC) || is_reg(addr, `SPGC_OFF_RX_SRC);
        end
    endfunction

    reg aw_have_q;
    reg [31:0] aw_addr_q;
    reg w_have_q;
    reg [31:0] w_data_q;
    reg w_strb0_q;
    reg transmit_enable_q;
    reg receive_enable_q;
    reg clock_redundancy_select_q;
    reg transmit_source_select_q;
    reg receive_source_select_q;
    reg serial_busy_q;
    reg buffer_busy_q;
    reg [CNT_W-1:0] serial_cnt_q;
    reg [CNT_W-1:0] buffer_cnt_q;
    reg [1:0] clk_a_s_q;
    reg [1:0] fs_a_s_q;
    reg [1:0] clk_b_s_q;
    reg [1:0] fs_b_s_q;
    wire do_write;
    wire wr_byte0;
    wire tx_clk_d;
    wire tx_fs_d;
    wire rx_clk_d;
    wire rx_fs_d;
    wire rx_side_b;
    reg [31:0] rd_val;

    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    // all fields live in byte lane 0, so only that strobe matters
    assign wr_byte0 = do_write && w_strb0_q;

    // write channel: address and data taken independently, either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPGC_RESP_OKAY;
            aw_have_q <= 1'b0;
            aw_addr_q <= 32'h00000000;
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb0_q <= 1'b0;
        end
        else
        begin
            if (!aw_have_q && !s_axi_bvalid && !s_axi_awready)
                s_axi_awready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (!w_have_q && !s_axi_bvalid && !s_axi_wready)
                s_axi_wready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr_q) ? `SPGC_RESP_OKAY : `SPGC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // control fields
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            transmit_enable_q <= 1'b0;
            receive_enable_q <= 1'b0;
            clock_redundancy_select_q <= 1'b0;
            transmit_source_select_q <= `SPGC_RST_SRC;
            receive_source_select_q <= `SPGC_RST_SRC;
        end
        else if (wr_byte0)
        begin
            if (is_reg(aw_addr_q, `SPGC_OFF_GLOBAL))
            begin
                transmit_enable_q <= w_data_q[`SPGC_BIT_TX_EN];
                receive_enable_q <= w_data_q[`SPGC_BIT_RX_EN];
                clock_redundancy_select_q <= w_data_q[`SPGC_BIT_CLK_RED];
            end
            // source is transmit configuration: locked while transmit is enabled
            if (is_reg(aw_addr_q, `SPGC_OFF_TX_SRC) && !transmit_enable_q)
            begin
                transmit_source_select_q <= w_data_q[`SPGC_BIT_SRC];
            end
            if (is_reg(aw_addr_q, `SPGC_OFF_RX_SRC))
            begin
                receive_source_select_q <= w_data_q[`SPGC_BIT_SRC];
            end
        end
    end

    // self-clearing unit resets; a new one-write restarts the count
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serial_busy_q <= 1'b0;
            buffer_busy_q <= 1'b0;
            serial_cnt_q <= {CNT_W{1'b0}};
            buffer_cnt_q <= {CNT_W{1'b0}};
        end
        else
        begin
            if (serial_busy_q)
            begin
                serial_cnt_q <= serial_cnt_q - 1'b1;
                if (serial_cnt_q == {{(CNT_W-1){1'b0}}, 1'b1})
                    serial_busy_q <= 1'b0;
            end
            if (buffer_busy_q)
            begin
                buffer_cnt_q <= buffer_cnt_q - 1'b1;
                if (buffer_cnt_q == {{(CNT_W-1){1'b0}}, 1'b1})
                    buffer_busy_q <= 1'b0;
            end
            // zero bits are simply not acted on
            if (wr_byte0 && is_reg(aw_addr_q, `SPGC_OFF_RESET))
            begin
                if (w_data_q[`SPGC_BIT_SERIAL_RST])
                begin
                    serial_busy_q <= 1'b1;
                    serial_cnt_q <= RST_LOAD;
                end
                if (w_data_q[`SPGC_BIT_BUFFER_RST])
                begin
                    buffer_busy_q <= 1'b1;
                    buffer_cnt_q <= RST_LOAD;
                end
            end
        end
    end

    always @*
    begin
        rd_val = 32'h00000000;
        if (is_reg(s_axi_araddr, `SPGC_OFF_RESET))
        begin
            rd_val[`SPGC_BIT_SERIAL_RST] = serial_busy_q;
            rd_val[`SPGC_BIT_BUFFER_RST] = buffer_busy_q;
        end
        else if (is_reg(s_axi_araddr, `SPGC_OFF_GLOBAL))
        begin
            rd_val[`SPGC_BIT_TX_EN] = transmit_enable_q;
            rd_val[`SPGC_BIT_RX_EN] = receive_enable_q;
            rd_val[`SPGC_BIT_CLK_RED] = clock_redundancy_select_q;
        end
        else if (is_reg(s_axi_araddr, `SPGC_OFF_TX_SRC))
            rd_val[`SPGC_BIT_SRC] = transmit_source_select_q;
        else if (is_reg(s_axi_araddr, `SPGC_OFF_RX_SRC))
            rd_val[`SPGC_BIT_SRC] = receive_source_select_q;
    end

    // read channel: one outstanding read, answer the cycle after arready
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPGC_RESP_OKAY;
        end
        else
        begin
            if (!s_axi_rvalid && !s_axi_arready)
                s_axi_arready <= 1'b1;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? `SPGC_RESP_OKAY : `SPGC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // pins are asynchronous; stage 0 feeds only stage 1
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_a_s_q <= 2'b00;
            fs_a_s_q <= 2'b00;
            clk_b_s_q <= 2'b00;
            fs_b_s_q <= 2'b00;
        end
        else
        begin
            clk_a_s_q <= {clk_a_s_q[0], timing_clock_side_a};
            fs_a_s_q <= {fs_a_s_q[0], frame_sync_side_a};
            clk_b_s_q <= {clk_b_s_q[0], timing_clock_side_b};
            fs_b_s_q <= {fs_b_s_q[0], frame_sync_side_b};
        end
    end

    assign tx_clk_d = transmit_source_select_q ? clk_b_s_q[1] : clk_a_s_q[1];
    assign tx_fs_d = transmit_source_select_q ? fs_b_s_q[1] : fs_a_s_q[1];
    // shared mode: receive follows the transmit choice, its own select unused
    assign rx_side_b = clock_redundancy_select_q ? receive_source_select_q
                                                 : transmit_source_select_q;
    assign rx_clk_d = rx_side_b ? clk_b_s_q[1] : clk_a_s_q[1];
    assign rx_fs_d = rx_side_b ? fs_b_s_q[1] : fs_a_s_q[1];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serial_unit_reset_q <= 1'b0;
            buffer_unit_reset_q <= 1'b0;
            transfer_unit_reset_q <= 1'b0;
            tx_run_q <= 1'b0;
            rx_run_q <= 1'b0;
            dual_clock_mode_q <= 1'b0;
            tx_clk_q <= 1'b0;
            tx_fs_q <= 1'b0;
            rx_clk_q <= 1'b0;
            rx_fs_q <= 1'b0;
            tx_clk_rise_q <= 1'b0;
            rx_clk_rise_q <= 1'b0;
        end
        else
        begin
            serial_unit_reset_q <= serial_busy_q;
            buffer_unit_reset_q <= buffer_busy_q;
            transfer_unit_reset_q <= buffer_busy_q;
            // neither side runs while the serial unit is held in reset, even if enabled; buffer reset does not stop them
            tx_run_q <= transmit_enable_q && !serial_busy_q;
            rx_run_q <= receive_enable_q && !serial_busy_q;
            dual_clock_mode_q <= clock_redundancy_select_q;
            tx_clk_q <= tx_clk_d;
            tx_fs_q <= tx_fs_d;
            rx_clk_q <= rx_clk_d;
            rx_fs_q <= rx_fs_d;
            // the registered clock already holds the previous sample, no extra stage
            tx_clk_rise_q <= tx_clk_d && !tx_clk_q;
            rx_clk_rise_q <= rx_clk_d && !rx_clk_q;
        end
    end

endmodule // spgc_top
`default_nettype wire

// ===== shared/spgc_map.vh
`ifndef SPGC_MAP_VH
`define SPGC_MAP_VH
`define SPGC_ADDR_W 8
`define SPGC_OFF_RESET 8'h08
`define SPGC_OFF_GLOBAL 8'h80
`define SPGC_OFF_TX_SRC 8'ha0
`define SPGC_OFF_RX_SRC 8'hc0
`define SPGC_BIT_SERIAL_RST 0
`define SPGC_BIT_BUFFER_RST 1
`define SPGC_BIT_TX_EN 0
`define SPGC_BIT_RX_EN 1
`define SPGC_BIT_CLK_RED 4
`define SPGC_BIT_SRC 0
`define SPGC_RST_GLOBAL 5'h00
`define SPGC_RST_SRC 1'b0
`define SPGC_RESET_CYCLES 16
`define SPGC_RESP_OKAY 2'b00
`define SPGC_RESP_SLVERR 2'b10
`endif

// ===== test/spgc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spgc_checker #(
    parameter int RESET_CYCLES = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic serial_unit_reset_q,
    input wire logic buffer_unit_reset_q,
    input wire logic transfer_unit_reset_q,
    input wire logic tx_run_q,
    input wire logic rx_run_q,
    input wire logic dual_clock_mode_q,
    input wire logic tx_clk_q,
    input wire logic rx_clk_q,
    input wire logic tx_clk_rise_q
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // a restart only lengthens a reset, so the bound is a floor
    logic [15:0] busy_q;
    always @(posedge aclk)
    begin
        if (!aresetn || !serial_unit_reset_q)
            busy_q <= 16'h0000;
        else
            busy_q <= busy_q + 16'h0001;
    end
    a_buf_xfer_pair: assert property (buffer_unit_reset_q == transfer_unit_reset_q)
        else $error("resets differ");
    a_reset_len: assert property ($fell(serial_unit_reset_q) |-> busy_q >= RESET_CYCLES)
        else $error("reset too short");
    a_run_in_reset: assert property (serial_unit_reset_q |-> !tx_run_q && !rx_run_q)
        else $error("runs in reset");
    a_shared_clk: assert property (!dual_clock_mode_q && !$past(dual_clock_mode_q) &&
        !$past(dual_clock_mode_q, 2) |-> rx_clk_q == tx_clk_q)
        else $error("shared clock differs");
    a_tx_rise: assert property (tx_clk_rise_q == (tx_clk_q && !$past(tx_clk_q)))
        else $error("bad rise pulse");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
        !(s_axi_araddr inside {32'h08, 32'h80, 32'ha0, 32'hc0}) |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read");
    cover property ($fell(serial_unit_reset_q));
    cover property (dual_clock_mode_q && rx_clk_q != tx_clk_q);
    cover property (tx_run_q && tx_clk_rise_q);
endmodule // spgc_checker
bind spgc_top spgc_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .serial_unit_reset_q(serial_unit_reset_q), .buffer_unit_reset_q(buffer_unit_reset_q),
    .transfer_unit_reset_q(transfer_unit_reset_q), .tx_run_q(tx_run_q), .rx_run_q(rx_run_q),
    .dual_clock_mode_q(dual_clock_mode_q), .tx_clk_q(tx_clk_q), .rx_clk_q(rx_clk_q),
    .tx_clk_rise_q(tx_clk_rise_q));
`default_nettype wire

// ===== test/spgc_timing_src.sv
`timescale 1ns/1ps
`default_nettype none
module spgc_timing_src (
    input wire logic run_b,
    output logic clk_a,
    output logic fs_a,
    output logic clk_b,
    output logic fs_b
);
    // side b parks low when stopped, as its pull-down would
    logic [2:0] n_q;
    initial
    begin
        clk_a = 1'b0;
        clk_b = 1'b0;
        n_q = 3'h0;
    end
    always
    begin
        #62.5;
        clk_a = !clk_a;
        clk_b = run_b && clk_a;
        if (clk_a)
            n_q = n_q + 3'h1;
    end
    assign fs_a = n_q == 3'h0;
    assign fs_b = run_b && fs_a;
endmodule // spgc_timing_src
`default_nettype wire

// ===== test/spgc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spgc_top_tb;
    localparam int RC = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, run_b = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] r;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire serial_unit_reset_q, buffer_unit_reset_q, transfer_unit_reset_q, tx_run_q, rx_run_q;
    wire dual_clock_mode_q, tx_clk_q, tx_fs_q, rx_clk_q, rx_fs_q, tx_clk_rise_q, rx_clk_rise_q;
    wire timing_clock_side_a, frame_sync_side_a, timing_clock_side_b, frame_sync_side_b;
    int n_errors = 0;
    int checks_done = 0;
    always #5 aclk = ~aclk;
    spgc_top #(.RESET_CYCLES(RC)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .timing_clock_side_a(timing_clock_side_a), .frame_sync_side_a(frame_sync_side_a),
        .timing_clock_side_b(timing_clock_side_b), .frame_sync_side_b(frame_sync_side_b),
        .serial_unit_reset_q(serial_unit_reset_q), .buffer_unit_reset_q(buffer_unit_reset_q),
        .transfer_unit_reset_q(transfer_unit_reset_q), .tx_run_q(tx_run_q), .rx_run_q(rx_run_q),
        .dual_clock_mode_q(dual_clock_mode_q), .tx_clk_q(tx_clk_q), .tx_fs_q(tx_fs_q),
        .rx_clk_q(rx_clk_q), .rx_fs_q(rx_fs_q), .tx_clk_rise_q(tx_clk_rise_q),
        .rx_clk_rise_q(rx_clk_rise_q));
    spgc_timing_src u_src (.run_b(run_b), .clk_a(timing_clock_side_a), .fs_a(frame_sync_side_a),
        .clk_b(timing_clock_side_b), .fs_b(frame_sync_side_b));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge aclk);
            aw = aw && s_axi_awready !== 1'b1;
            w = w && s_axi_wready !== 1'b1;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do
            @(posedge aclk);
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] rexp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, rexp});
    endtask
    // a stopped side may still show a few cycles of its last frame sync, hence the floor
    task automatic rises(input logic tx_exp, input logic rx_exp);
        int nt;
        int nr;
        int ft;
        int fr;
        nt = 0;
        nr = 0;
        ft = 0;
        fr = 0;
        repeat (205)
        begin
            @(posedge aclk);
            nt += (tx_clk_rise_q === 1'b1);
            nr += (rx_clk_rise_q === 1'b1);
            ft += (tx_fs_q === 1'b1);
            fr += (rx_fs_q === 1'b1);
        end
        chk({31'h0, nt > 1}, {31'h0, tx_exp});
        chk({31'h0, nr > 1}, {31'h0, rx_exp});
        chk({31'h0, ft > 4}, {31'h0, tx_exp});
        chk({31'h0, fr > 4}, {31'h0, rx_exp});
    endtask
    task complete_run;
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_errors++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run;
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(32'h08, 32'h0, 2'b00);
        rd(32'h80, 32'h0, 2'b00);
        rd(32'ha0, 32'h0, 2'b00);
        rd(32'hc0, 32'h0, 2'b00);
        rd(32'h04, 32'h0, 2'b10);
        wr(32'h04, 32'hff);
        chk({30'h0, r}, 32'h2);
        wr(32'h08, 32'h0);
        rd(32'h08, 32'h0, 2'b00);
        wr(32'h08, 32'h1);
        rd(32'h08, 32'h1, 2'b00);
        chk({29'h0, serial_unit_reset_q, buffer_unit_reset_q, transfer_unit_reset_q}, 32'h4);
        repeat (RC + 10) @(posedge aclk);
        wr(32'h08, 32'h2);
        rd(32'h08, 32'h2, 2'b00);
        chk({29'h0, serial_unit_reset_q, buffer_unit_reset_q, transfer_unit_reset_q}, 32'h3);
        repeat (RC + 10) @(posedge aclk);
        wr(32'h08, 32'h3);
        rd(32'h08, 32'h3, 2'b00);
        chk({29'h0, serial_unit_reset_q, buffer_unit_reset_q, transfer_unit_reset_q}, 32'h7);
        wr(32'h08, 32'h0);
        rd(32'h08, 32'h3, 2'b00);
        repeat (RC + 10) @(posedge aclk);
        rd(32'h08, 32'h0, 2'b00);
        s_axi_wstrb <= 4'he;
        wr(32'h80, 32'h13);
        s_axi_wstrb <= 4'hf;
        rd(32'h80, 32'h0, 2'b00);
        wr(32'h80, 32'h13);
        rd(32'h80, 32'h13, 2'b00);
        chk({29'h0, tx_run_q, rx_run_q, dual_clock_mode_q}, 32'h7);
        wr(32'ha0, 32'h1);
        chk({30'h0, r}, 32'h0);
        rd(32'ha0, 32'h0, 2'b00);
        wr(32'h80, 32'h10);
        wr(32'ha0, 32'h1);
        rd(32'ha0, 32'h1, 2'b00);
        chk({30'h0, tx_run_q, rx_run_q}, 32'h0);
        rises(1'b0, 1'b1);
        wr(32'hc0, 32'h1);
        rd(32'hc0, 32'h1, 2'b00);
        rises(1'b0, 1'b0);
        run_b <= 1'b1;
        rises(1'b1, 1'b1);
        wr(32'h80, 32'h0);
        run_b <= 1'b0;
        rises(1'b0, 1'b0);
        wr(32'ha0, 32'h0);
        rises(1'b1, 1'b1);
        wr(32'h80, 32'h1);
        rd(32'h80, 32'h1, 2'b00);
        chk({30'h0, tx_run_q, rx_run_q}, 32'h2);
        repeat (50) @(posedge aclk);
        complete_run;
    end
endmodule // spgc_top_tb
`default_nettype wire
